// *** src/swe_pkg.sv ***
/*
  Constants, field layout and carrier types for the single-wire echo UART.
  Assumes a 10 MHz pclk and APB with 32-bit data, one register per word.
*/
`default_nettype none
package swe_pkg;
  localparam int          CLK_HZ      = 10_000_000;
  localparam int          BAUD_DEF    = 76800;
  localparam logic [15:0] RXDIV_RST   = 16'(CLK_HZ / BAUD_DEF - 1);
  localparam logic [15:0] RELOAD_RST  = 16'h0103;
  localparam logic [7:0]  FILL_ONES   = 8'hff;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          FIFO_WIDTH  = 8;

  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_RXDIV   = 8'h04;
  localparam logic [7:0]  OFS_RELOAD  = 8'h08;
  localparam logic [7:0]  OFS_STATUS  = 8'h0c;

  localparam int          CTRL_SEVEN  = 0;
  localparam int          CTRL_PAR    = 1;
  localparam int          CTRL_RXEN   = 3;
  localparam int          CTRL_HOLD   = 4;
  localparam int          ST_TXBUSY   = 0;
  localparam int          ST_RXBUSY   = 1;
  localparam int          ST_PARERR   = 2;
  localparam int          ST_FRMERR   = 3;
  localparam int          ST_LEVEL    = 4;
  localparam int          ST_LAST     = 8;

  typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_NONE, PAR_RSVD} swe_par_t;

  typedef struct packed {
    logic     hold;
    logic     rx_en;
    swe_par_t par;
    logic     seven;
  } swe_cfg_t;

  localparam swe_cfg_t CTRL_RST = '{hold: 1'b0, rx_en: 1'b1, par: PAR_EVEN, seven: 1'b0};

  typedef struct packed {
    logic out;
    logic oe;
  } swe_pin_t;
endpackage
`default_nettype wire

// *** src/swe_echo.sv ***
/*
  Single-wire UART echo: receiver, character FIFO, bit timer and frame
  shifter sharing one line pin, with an APB register slave.
  Assumes the line pin is synchronous to pclk and pulled high outside
  this block; the remote side stays quiet while an echo is in flight.
*/
// Notes on behaviour
// - characters are eight or seven data bits, same length both directions
// - data bits travel least significant bit first, receive and transmit
// - parity even, odd or none; even after reset
// - receiver reads the line non-inverted, high is one
// - bit rate is programmable; receiver defaults to 76800 bit/s
// - receiver raises a receive-complete event for every character
// - bit timer reload is 259, a period of 260 counts per bit
// - bit timer repeats in interval mode, started only from inside
// - bit timer never drives its own output pin
// - 16-bit frame: data low, 0xff above, shifted left for start bit
// - parity bit, when enabled, follows directly after the data bits
// - to transmit: stop receiver, turn pin to output, start timer
// - each tick but the last shifts the frame right and drives the bit out
// - after the full frame count, stop timer and restart receiver
// - echo exactly the received character in the same format
// - bit tick handling takes precedence over receive-complete handling
`timescale 1ns/1ps
`default_nettype none

module swe_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  logic         push;
  logic         pop;

  assign level     = wp - rp;
  assign in_ready  = (level != (AW+1)'(D));
  assign out_valid = (wp != rp);
  assign out_data  = mem[rp[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule // swe_fifo

module swe_echo
  import swe_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        line_in,
  output logic             line_out,
  output logic             line_oe,
  output logic             timer_output_pin,
  output logic             timer_output_pin_oe,
  output logic             rx_done_event,
  output logic             bit_tick_event
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_PUSH} swe_rx_t;
  typedef enum logic [0:0] {TX_IDLE, TX_RUN} swe_tx_t;

  swe_cfg_t    cfg;
  logic [15:0] rx_div;
  logic [15:0] bit_period_reload;
  logic        par_err;
  logic        frm_err;
  logic [7:0]  last_char;

  swe_rx_t     rx_state;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_idx;
  logic [8:0]  rx_sh;
  logic [7:0]  rx_data;
  logic        rx_run;
  logic        rx_pbit;
  logic        rx_pcalc;

  swe_tx_t     tx_state;
  logic [15:0] frame;
  logic [3:0]  remain;
  logic [3:0]  tot;
  logic        tx_start;
  logic        tx_finish;
  logic [15:0] next_word;

  logic        tmr_run;
  logic [15:0] tmr_cnt;
  logic        tick;

  logic [3:0]  nbits;
  logic        par_on;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic [3:0]  fifo_level;
  logic        push;
  logic        acc;
  logic        wr;
  logic        mapped;
  logic        clr_par;
  logic        clr_frm;
  logic        set_par;
  logic        set_frm;

  assign nbits  = cfg.seven ? 4'd7 : 4'd8;
  assign par_on = (cfg.par == PAR_EVEN) || (cfg.par == PAR_ODD);

  // apb slave: one wait state, so the answer comes two edges after setup
  assign acc    = psel & penable;
  assign wr     = acc & pready & pwrite & ~pslverr;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_RXDIV) ||
                  (paddr == OFS_RELOAD) || (paddr == OFS_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      if (acc & ~pready & ~pwrite) begin
        case (paddr)
          OFS_CTRL:   prdata <= {27'h0, cfg};
          OFS_RXDIV:  prdata <= {16'h0, rx_div};
          OFS_RELOAD: prdata <= {16'h0, bit_period_reload};
          OFS_STATUS: begin
            prdata              <= 32'h0;
            prdata[ST_TXBUSY]   <= (tx_state == TX_RUN);
            prdata[ST_RXBUSY]   <= (rx_state != RX_IDLE);
            prdata[ST_PARERR]   <= par_err;
            prdata[ST_FRMERR]   <= frm_err;
            prdata[ST_LEVEL+:4] <= fifo_level;
            prdata[ST_LAST+:8]  <= last_char;
          end
          default:    prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg               <= CTRL_RST;
      rx_div            <= RXDIV_RST;
      bit_period_reload <= RELOAD_RST;
    end else if (wr) begin
      case (paddr)
        OFS_CTRL:   cfg <= swe_cfg_t'(pwdata[4:0]);
        OFS_RXDIV:  rx_div <= pwdata[15:0];
        OFS_RELOAD: bit_period_reload <= pwdata[15:0];
        default:    ;
      endcase
    end
  end

  // sticky error flags, write one to clear; a new error wins the clear
  assign clr_par = wr && (paddr == OFS_STATUS) && pwdata[ST_PARERR];
  assign clr_frm = wr && (paddr == OFS_STATUS) && pwdata[ST_FRMERR];
  assign set_par = (rx_state == RX_STOP) && (rx_cnt == 16'h0) && par_on && (rx_pbit != rx_pcalc);
  assign set_frm = (rx_state == RX_STOP) && (rx_cnt == 16'h0) && !line_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_err <= 1'b0;
      frm_err <= 1'b0;
    end else begin
      par_err <= set_par | (par_err & ~clr_par);
      frm_err <= set_frm | (frm_err & ~clr_frm);
    end
  end

  // receiver; halted whenever the line is turned round for transmit
  assign rx_run   = cfg.rx_en & (tx_state == TX_IDLE) & ~tx_start;
  assign rx_data  = cfg.seven ? {1'b0, rx_sh[6:0]} : rx_sh[7:0];
  assign rx_pbit  = rx_sh[nbits];
  assign rx_pcalc = (^rx_data) ^ (cfg.par == PAR_ODD);
  assign push     = (rx_state == RX_PUSH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= 16'h0;
      rx_idx   <= 4'h0;
      rx_sh    <= 9'h0;
    end else if (!rx_run && rx_state != RX_PUSH) begin
      rx_state <= RX_IDLE;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          if (!line_in) begin
            rx_cnt   <= {1'b0, rx_div[15:1]};
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt != 16'h0) begin
            rx_cnt <= rx_cnt - 1'b1;
          end else if (line_in) begin
            rx_state <= RX_IDLE;
          end else begin
            rx_cnt   <= rx_div;
            rx_idx   <= 4'h0;
            rx_sh    <= 9'h0;
            rx_state <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (rx_cnt != 16'h0) begin
            rx_cnt <= rx_cnt - 1'b1;
          end else begin
            rx_cnt        <= rx_div;
            rx_sh[rx_idx] <= line_in;
            rx_idx        <= rx_idx + 1'b1;
            if (rx_idx == nbits - {3'h0, ~par_on}) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_cnt != 16'h0) begin
            rx_cnt <= rx_cnt - 1'b1;
          end else begin
            rx_state <= RX_PUSH;
          end
        end
        RX_PUSH: begin
          // a full fifo stalls here, holding off the next character
          if (fifo_in_ready) begin
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_done_event <= 1'b0;
      last_char     <= 8'h0;
    end else begin
      rx_done_event <= push & fifo_in_ready;
      if (push & fifo_in_ready) begin
        last_char <= rx_data;
      end
    end
  end

  swe_fifo #(
    .W (FIFO_WIDTH),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_data   (rx_data),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (tx_start),
    .level     (fifo_level)
  );

  // bit timer: interval mode, reloads itself, started only by tx_start
  assign tick = tmr_run && (tmr_cnt == 16'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_run        <= 1'b0;
      tmr_cnt        <= 16'h0;
      bit_tick_event <= 1'b0;
    end else begin
      bit_tick_event <= tick;
      if (tx_start) begin
        tmr_run <= 1'b1;
        tmr_cnt <= bit_period_reload;
      end else if (tx_finish) begin
        tmr_run <= 1'b0;
      end else if (tick) begin
        tmr_cnt <= bit_period_reload;
      end else if (tmr_run) begin
        tmr_cnt <= tmr_cnt - 1'b1;
      end
    end
  end

  // the timer's own pin stays quiet; only the line port carries data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_output_pin    <= 1'b0;
      timer_output_pin_oe <= 1'b0;
    end else begin
      timer_output_pin    <= 1'b0;
      timer_output_pin_oe <= 1'b0;
    end
  end

  // frame build: data low, ones above, parity dropped in after data
  always_comb begin
    next_word        = {FILL_ONES, fifo_out_data};
    if (cfg.seven) begin
      next_word[7] = 1'b1;
    end
    if (par_on) begin
      next_word[nbits] = (^(cfg.seven ? {1'b0, fifo_out_data[6:0]} : fifo_out_data))
                         ^ (cfg.par == PAR_ODD);
    end
  end

  // tick work is done in the same cycle it fires, never deferred
  assign tx_start  = (tx_state == TX_IDLE) && fifo_out_valid && !cfg.hold &&
                     (rx_state == RX_IDLE) && line_in;
  assign tx_finish = (tx_state == TX_RUN) && tick && (remain == 4'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= TX_IDLE;
      frame    <= 16'hffff;
      remain   <= 4'h0;
      tot      <= 4'h0;
      line_out <= 1'b1;
      line_oe  <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_start) begin
            frame    <= {next_word[14:0], 1'b0};
            remain   <= nbits + {3'h0, par_on} + 4'd2;
            tot      <= nbits + {3'h0, par_on} + 4'd2;
            line_out <= 1'b1;
            line_oe  <= 1'b1;
            tx_state <= TX_RUN;
          end
        end
        TX_RUN: begin
          if (tx_finish) begin
            line_oe  <= 1'b0;
            line_out <= 1'b1;
            tx_state <= TX_IDLE;
          end else if (tick) begin
            line_out <= frame[0];
            frame    <= {1'b1, frame[15:1]};
            remain   <= remain - 1'b1;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // checking helpers
  logic [15:0] gap;
  logic        gap_ok;
  logic        fr0;
  assign fr0 = frame[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap    <= 16'h0;
      gap_ok <= 1'b0;
    end else if (tx_start || tick) begin
      gap    <= 16'h0;
      gap_ok <= 1'b1;
    end else begin
      gap <= gap + 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_load;
    tx_start;
  endsequence

  sequence s_first_tick;
    (tx_state == TX_RUN) && tick && (remain == tot);
  endsequence

  sequence s_end;
    tx_finish;
  endsequence

  a_echo_turnaround: assert property (s_load |=> line_oe && line_out && tmr_run)
    else $error("line not turned to output with timer running");

  a_rx_halted: assert property (line_oe |-> rx_state == RX_IDLE || rx_state == RX_PUSH)
    else $error("receiver active while driving the line");

  // bit 9 may hold the parity of an eight-bit character, every bit above is fill
  a_frame_fill: assert property (s_load |=> frame[0] == 1'b0 && frame[15:10] == 6'h3f &&
                                 (frame[9] || (par_on && !cfg.seven)))
    else $error("frame word not built with start bit and ones above");

  a_start_low: assert property (s_first_tick |=> !line_out ##1 line_oe)
    else $error("first bit of frame is not a low start bit");

  a_lsb_shift: assert property ((tx_state == TX_RUN) && tick && remain != 4'h0 |=> line_out == $past(fr0))
    else $error("shifted bit not driven onto the line");

  a_tick_gap: assert property (tick && gap_ok |-> gap == bit_period_reload)
    else $error("bit period differs from reload plus one");

  // checked one cycle on only: a queued character may start the next echo right after
  a_return_rx: assert property (s_end |=> !line_oe && !tmr_run && (tx_state == TX_IDLE))
    else $error("timer or output not released at frame end");

  a_timer_pin_off: assert property (!timer_output_pin_oe && !timer_output_pin)
    else $error("timer output pin driven");

  a_rx_event: assert property (push && fifo_in_ready |=> rx_done_event ##1 !rx_done_event)
    else $error("receive-complete event missing or stretched");

  a_tick_event: assert property (tick |=> bit_tick_event)
    else $error("bit tick event not reported");

  a_timer_soft: assert property ($rose(tmr_run) |-> $past(tx_start))
    else $error("bit timer started without the internal trigger");
endmodule // swe_echo
`default_nettype wire

// *** tb/swe_remote.sv ***
/*
  Behavioural remote UART sharing the single line with the echo block.
  Assumes the bench resolves the line with a pull-up and calls the tasks
  in turn: it never sends while an echo frame is on the line.
*/
`timescale 1ns/1ps
`default_nettype none

module swe_remote (
  input  wire logic pclk,
  input  wire logic line,
  output logic      drv_out,
  output logic      drv_oe
);
  initial begin
    drv_out = 1'b1;
    drv_oe  = 1'b0;
  end

  // par: 0 even, 1 odd, 2 none; per: bit period in pclk cycles
  task automatic send(input logic [7:0] d, input int nb, input int par, input int per);
    logic [11:0] fr;
    int          n;
    fr    = '1;
    fr[0] = 1'b0;
    for (int i = 0; i < nb; i++) begin
      fr[i+1] = d[i];
    end
    n = nb + 1;
    if (par < 2) begin
      fr[n] = (par == 1) ^ (^(d & ((nb == 7) ? 8'h7f : 8'hff)));
      n++;
    end
    fr[n] = 1'b1;
    n++;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      drv_oe  <= 1'b1;
      drv_out <= fr[i];
      repeat (per - 1) @(posedge pclk);
    end
    // release at once so the echo may follow; the pull-up keeps idle high
    @(posedge pclk);
    drv_oe <= 1'b0;
  endtask

  // samples at mid-bit, so a wrong bit period shows as wrong bits
  task automatic recv(input int nb, input int par, input int per,
                      output logic [7:0] d, output logic p, output logic s, output logic st);
    d = 8'h00;
    p = 1'b0;
    @(negedge line);
    repeat (per / 2) @(posedge pclk);
    st = line;
    for (int i = 0; i < nb; i++) begin
      repeat (per) @(posedge pclk);
      d[i] = line;
    end
    if (par < 2) begin
      repeat (per) @(posedge pclk);
      p = line;
    end
    repeat (per) @(posedge pclk);
    s = line;
  endtask
endmodule // swe_remote

`default_nettype wire

// *** tb/testbench.sv ***
/*
  Self-checking bench for the single-wire echo UART: APB register access,
  echo in every format, and FIFO fill with echo held back.
  Assumes swe_pkg, swe_echo and the remote model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import swe_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, line_out, line_oe, tpin, tpin_oe, rx_done_event, bit_tick_event;
  logic        rem_out, rem_oe, line;
  int          err_count   = 0;
  int          checks_done = 0;
  int          dones       = 0;
  int          ticks       = 0;

  always #50 pclk = ~pclk;
  // pull-up on the shared line when nobody drives it
  assign line = line_oe ? line_out : (rem_oe ? rem_out : 1'b1);

  swe_echo uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line), .line_out(line_out), .line_oe(line_oe), .timer_output_pin(tpin),
    .timer_output_pin_oe(tpin_oe), .rx_done_event(rx_done_event), .bit_tick_event(bit_tick_event));
  swe_remote rem (.pclk(pclk), .line(line), .drv_out(rem_out), .drv_oe(rem_oe));

  always @(posedge pclk) begin
    if (rx_done_event === 1'b1) dones <= dones + 1;
    if (bit_tick_event === 1'b1) ticks <= ticks + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    check(what, rd, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic wait_oe(input logic lvl);
    int n;
    n = 0;
    while (line_oe !== lvl && n < 400) begin
      @(posedge pclk);
      n++;
    end
  endtask

  function automatic logic par_of(input logic [7:0] d, input int nb, input int par);
    return (par == 1) ^ (^(d & ((nb == 7) ? 8'h7f : 8'hff)));
  endfunction

  // takes one echo frame off the line and judges it
  task automatic take_echo(input logic [7:0] c, input int nb, input int par);
    logic [7:0] d;
    logic       p, s, st;
    rem.recv(nb, par, int'(RELOAD_RST) + 1, d, p, s, st);
    check("start bit", {31'h0, st}, 32'h0);
    check("echo data", {24'h0, d}, {24'h0, c & ((nb == 7) ? 8'h7f : 8'hff)});
    if (par < 2) check("parity", {31'h0, p}, {31'h0, par_of(c, nb, par)});
    check("stop bit", {31'h0, s}, 32'h1);
  endtask

  task automatic t_reset;
    logic [31:0] rd;
    logic        er;
    rdchk("ctrl reset", OFS_CTRL, 32'h08);
    rdchk("rxdiv reset", OFS_RXDIV, 32'd129);
    rdchk("reload reset", OFS_RELOAD, 32'h103);
    rdchk("status reset", OFS_STATUS, 32'h0);
    apb(1'b0, 8'h10, 32'h0, rd, er);
    check("unmapped err", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, 8'h10, 32'hffff_ffff, rd, er);
    check("unmapped wr err", {31'h0, er}, 32'h1);
    wr(OFS_RELOAD, 32'hffff_1234);
    rdchk("reload write", OFS_RELOAD, 32'h1234);
    wr(OFS_RELOAD, {16'h0, RELOAD_RST});
    rdchk("reload restore", OFS_RELOAD, {16'h0, RELOAD_RST});
    check("line idle", {30'h0, line_oe, line_out}, 32'h1);
    $display("test reset done");
  endtask

  task automatic echo_one(input logic [7:0] c, input int nb, input int par);
    int d0;
    d0 = dones;
    rem.send(c, nb, par, 130);
    wait_oe(1'b1);
    check("line turned", {30'h0, line_oe, line_out}, 32'h3);
    check("rx event", dones, d0 + 1);
    rdchk("busy status", OFS_STATUS, {16'h0, c & ((nb == 7) ? 8'h7f : 8'hff), 8'h01});
    ticks = 0;
    take_echo(c, nb, par);
    wait_oe(1'b0);
    repeat (3) @(posedge pclk);
    check("line released", {31'h0, line_oe}, 32'h0);
    check("tick count", ticks, nb + (par < 2) + 3);
    check("timer pin", {30'h0, tpin, tpin_oe}, 32'h0);
  endtask

  task automatic t_modes;
    for (int sv = 0; sv < 2; sv++) begin
      for (int pm = 0; pm < 3; pm++) begin
        wr(OFS_CTRL, 32'h08 | (pm << 1) | sv);
        echo_one(8'ha5 ^ 8'(sv * 3 + pm), 8 - sv, pm);
        rdchk("last char", OFS_STATUS, {16'h0, (8'ha5 ^ 8'(sv * 3 + pm)) & (sv ? 8'h7f : 8'hff), 8'h0});
      end
    end
    wr(OFS_CTRL, 32'h08);
    $display("test modes done");
  endtask

  // odd parity sent against the even setting: flag set, echo still goes out
  task automatic t_parerr;
    rem.send(8'h5a, 8, 1, 130);
    take_echo(8'h5a, 8, 0);
    wait_oe(1'b0);
    rdchk("parity flag", OFS_STATUS, {16'h0, 8'h5a, 8'h04});
    wr(OFS_STATUS, 32'h4);
    rdchk("parity clear", OFS_STATUS, {16'h0, 8'h5a, 8'h00});
    $display("test parity error done");
  endtask

  task automatic t_fifo;
    int d0;
    d0 = dones;
    wr(OFS_CTRL, 32'h18);
    // back-to-back frames while the echo is held back
    for (int k = 0; k < FIFO_DEPTH; k++) rem.send(8'h30 + 8'(k), 8, 0, 130);
    repeat (5) @(posedge pclk);
    check("held events", dones, d0 + FIFO_DEPTH);
    check("held line", {31'h0, line_oe}, 32'h0);
    rdchk("full level", OFS_STATUS, {16'h0, 8'h37, 8'h80});
    wr(OFS_CTRL, 32'h08);
    for (int k = 0; k < FIFO_DEPTH; k++) take_echo(8'h30 + 8'(k), 8, 0);
    wait_oe(1'b0);
    rdchk("empty level", OFS_STATUS, {16'h0, 8'h37, 8'h00});
    $display("test fifo done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_modes;
    t_parerr;
    t_fifo;
    give_verdict;
  end

  // about 70k cycles expected; cut off at 100k
  initial begin
    #(100 * 100_000);
    err_count++;
    give_verdict;
  end
endmodule // testbench

`default_nettype wire
